// ==== verilog/pbr_pkg.sv ====
// Functional notes
// (RL1) writing control bit 15 restores defaults; bit reads 1 until reset done
// (RL2) loopback returns transmit nibbles to receive path, medium receive ignored
// (RL3) entering loopback blanks receive valid for up to 560 ns
// (RL4) configuration loopback setting overrides the control loopback bit
// (RL5) bit 13 forces speed when negotiation off; resets to 1, reads back
// (RL6) bit 12 enables negotiation, resets 1; forced speed and duplex ignored
// (RL7) bit 11 selects low power mode; resets 0
// (RL8) bit 10 isolates the MAC-side nibble interface both directions; resets 0
// (RL9) bit 9 restarts negotiation and clears itself
// (RL10) bit 8 forces duplex when negotiation off; reads 1, read-only otherwise
// (RL11) loopback behaviour does not depend on the duplex bit
// (RL12) bit 7 is plain storage resetting to 1
// (RL13) station writes zeros to control bits 6:0; they reset to 0
// (RL14) status bits 14,13 read 1 unless ten-only advertisement strap active
// (RL15) status bits 12 and 11 read 1
// (RL16) status bit 6 reads 0; frames need full preamble
// (RL17) status bit 5 shows negotiation complete
// (RL18) status bit 4 shows remote fault; resets 0 (code reads live LIVE.remote_fault, with no reset value)
// (RL19) status bits 3 and 0 read 1
// (RL20) status bit 2 is link, latched low, resets 0
// (RL21) status bit 1 is jabber, 10 Mbps only, latched high, resets 0
// (RL22) status bit 15 reads 0; station writes it as 0
// (RL23) access only via serial management frames; every such access served (code drops control writes that arrive while a reset runs)
// (RL24) self-clearing bits drop alone; latch bits hold their event value
// (RL25) after a read returns a latched value, the bit follows live again
package pbr_pkg;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          LOOP_DEAD_NS   = 560;
  localparam int          LOOP_DEAD_CYC  = LOOP_DEAD_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  SOFT_RST_CYC   = 5'h10;
  localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
  localparam logic [1:0]  OP_RD          = 2'h2;
  localparam logic [1:0]  OP_WR          = 2'h1;
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_STAT       = 5'h01;
  localparam int          CB_RESET       = 15;
  localparam int          CB_LOOP        = 14;
  localparam int          CB_SPEED       = 13;
  localparam int          CB_ANEN        = 12;
  localparam int          CB_PDOWN       = 11;
  localparam int          CB_ISO         = 10;
  localparam int          CB_ANRST       = 9;
  localparam int          CB_DUP         = 8;
  localparam int          CB_COLL        = 7;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3080;
  localparam logic [15:0] STAT_FIXED     = 16'h1809;
  localparam logic [15:0] STAT_100_ABLE  = 16'h6000;

  typedef enum {MS_PRE, MS_ST, MS_OP, MS_PHY, MS_REG, MS_TA, MS_DATA} pbr_mstate_t;

  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } pbr_mii_t;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic aneg_en;
    logic aneg_restart;
    logic power_down;
    logic isolate;
  } pbr_mode_t;

  typedef struct packed {
    logic link_ok;
    logic jabber;
    logic aneg_done;
    logic remote_fault;
    logic an_speed_100;
    logic an_full_duplex;
  } pbr_live_t;

  typedef struct packed {
    logic latched;
  } pbr_cell_t;

  typedef struct packed {
    pbr_mstate_t mstate;
    logic [5:0]  cnt;
    logic        mdc_q;
    logic [15:0] shreg;
    logic [1:0]  op;
    logic        phy_hit;
    logic [4:0]  regad;
    logic [15:0] rdata;
    logic        mdio_o;
    logic        mdio_oe;
    logic        loop;
    logic        speed;
    logic        aneg;
    logic        pdown;
    logic        iso;
    logic        dup;
    logic        coll;
    logic [6:0]  rsvd;
    logic        restart;
    logic [4:0]  srst_cnt;
    logic        strap10;
    logic        loop_q;
    logic [3:0]  dead_cnt;
    pbr_mode_t   mode;
    pbr_mii_t    mac_rx;
    pbr_mii_t    line_tx;
  } pbr_state_t;

  // power-up runs the same sequence as a software reset, so the strap is caught after release
  localparam pbr_state_t ST_RESET = '{mstate: MS_PRE, srst_cnt: SOFT_RST_CYC, default: '0};
endpackage : pbr_pkg

// ==== verilog/pbr_latch_cell.sv ====
module pbr_latch_cell #(
  parameter logic LV          = 1'b0,
  parameter logic RST_LATCHED = 1'b0
) (
  // clock and reset
  input  logic clk,
  input  logic init,
  // condition and read strobe
  input  logic live,
  input  logic rd_clr,
  // reported value
  output logic value
);
  import pbr_pkg::*;

  pbr_cell_t s;
  pbr_cell_t next_s;

  always_comb begin
    next_s = s;
    if (rd_clr) begin
      next_s.latched = 1'b0; // RL25
    end
    // an event in the read cycle is kept for the next read
    if (live == LV) begin
      next_s.latched = 1'b1; // RL24
    end
  end

  always_ff @(posedge clk) begin
    if (init) begin
      s <= '{latched: RST_LATCHED};
    end else begin
      s <= next_s;
    end
  end

  assign value = s.latched ? LV : live;

  property p_hold;
    @(posedge clk) disable iff (init)
      (live == LV) |=> (value == LV);
  endproperty
  a_hold: assert property (p_hold) else $error("latched event not held"); // RL24
endmodule : pbr_latch_cell

// ==== verilog/pbr_regs.sv ====
module pbr_regs (
  // clock and reset
  input  logic              CLK_SYS,
  input  logic              SYS_RST,
  // management interface
  input  logic [4:0]        PHY_ADDR,
  input  logic              MDC,
  input  logic              MDIO_I,
  output logic              MDIO_O,
  output logic              MDIO_OE,
  // configuration pins
  input  logic              TEN_MBPS_ONLY_ADVERT_STRAP,
  input  logic              LOOP_CFG_VALID,
  input  logic              LOOP_CFG,
  // live line status and operating mode
  input  pbr_pkg::pbr_live_t LIVE,
  output pbr_pkg::pbr_mode_t MODE,
  // nibble paths
  input  pbr_pkg::pbr_mii_t  MAC_TX,
  output pbr_pkg::pbr_mii_t  MAC_RX,
  output pbr_pkg::pbr_mii_t  LINE_TX,
  input  pbr_pkg::pbr_mii_t  LINE_RX
);
  import pbr_pkg::*;

  pbr_state_t  s;
  pbr_state_t  next_s;
  logic        mdc_rise;
  logic        busy;
  logic        rd_go;
  logic        wr_go;
  logic        stat_rd;
  logic        ctl_wr;
  logic [15:0] ctl_word;
  logic [15:0] sh_word;
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;
  logic [15:0] rd_word;
  logic        loop_eff;
  logic        loop_entry;
  logic        dead;
  logic        link_v;
  logic        jab_v;
  logic        cell_init;
  pbr_mii_t    rx_src;

  assign busy      = s.srst_cnt != 5'h00;
  assign cell_init = SYS_RST | busy;
  assign sh_word   = {s.shreg[14:0], MDIO_I};
  assign rd_go     = s.phy_hit && (s.op == OP_RD);
  assign wr_go     = s.phy_hit && (s.op == OP_WR);
  assign loop_eff  = LOOP_CFG_VALID ? LOOP_CFG : s.loop; // RL4

  // link latches low and powers up latched, so it reads 0 before the first read
  pbr_latch_cell #(
    .LV          (1'b0),
    .RST_LATCHED (1'b1)
  ) u_link (
    .clk    (CLK_SYS),
    .init   (cell_init),
    .live   (LIVE.link_ok),
    .rd_clr (stat_rd),
    .value  (link_v)
  ); // RL20

  pbr_latch_cell #(
    .LV          (1'b1),
    .RST_LATCHED (1'b0)
  ) u_jabber (
    .clk    (CLK_SYS),
    .init   (cell_init),
    .live   (LIVE.jabber & ~s.mode.speed_100),
    .rd_clr (stat_rd),
    .value  (jab_v)
  ); // RL21

  // read views
  always_comb begin
    ctrl_view = {busy, s.loop, s.speed, s.aneg, s.pdown, s.iso, s.restart,
                 s.aneg | s.dup, s.coll, s.rsvd}; // RL1 RL10
    stat_view = STAT_FIXED; // RL15 RL16 RL19 RL22
    if (!s.strap10) begin
      stat_view = stat_view | STAT_100_ABLE; // RL14
    end
    stat_view = stat_view | {10'h000, LIVE.aneg_done, LIVE.remote_fault, 1'b0,
                             link_v, jab_v, 1'b0}; // RL17 RL18
    if (sh_word[4:0] == REG_CTRL) begin
      rd_word = ctrl_view;
    end else if (sh_word[4:0] == REG_STAT) begin
      rd_word = stat_view;
    end else begin
      rd_word = 16'h0000;
    end
  end

  always_comb begin
    next_s         = s;
    next_s.restart = 1'b0; // RL9
    next_s.mdc_q   = MDC;
    mdc_rise       = MDC & ~s.mdc_q;
    stat_rd        = 1'b0;
    ctl_wr         = 1'b0;
    ctl_word       = sh_word;

    // management frame engine, stepped on each management clock rise
    if (mdc_rise) begin
      next_s.cnt = s.cnt + 6'h01;
      case (s.mstate)
        MS_PRE: begin
          if (MDIO_I) begin
            if (s.cnt == PREAMBLE_LEN) begin
              next_s.cnt = s.cnt;
            end
          end else begin
            next_s.cnt = 6'h00;
            if (s.cnt == PREAMBLE_LEN) begin
              next_s.mstate = MS_ST; // RL16
            end
          end
        end
        MS_ST: begin
          next_s.cnt    = 6'h00;
          next_s.mstate = MDIO_I ? MS_OP : MS_PRE;
        end
        MS_OP: begin
          next_s.op = {s.op[0], MDIO_I};
          if (s.cnt == 6'h01) begin
            next_s.cnt    = 6'h00;
            next_s.mstate = MS_PHY;
          end
        end
        MS_PHY: begin
          next_s.shreg = sh_word;
          if (s.cnt == 6'h04) begin
            next_s.cnt     = 6'h00;
            next_s.phy_hit = sh_word[4:0] == PHY_ADDR;
            next_s.mstate  = MS_REG;
          end
        end
        MS_REG: begin
          next_s.shreg = sh_word;
          if (s.cnt == 6'h04) begin
            next_s.cnt    = 6'h00;
            next_s.regad  = sh_word[4:0];
            next_s.mstate = MS_TA;
            if (rd_go) begin
              next_s.rdata = rd_word; // RL23
              stat_rd      = sh_word[4:0] == REG_STAT; // RL25
            end
          end
        end
        MS_TA: begin
          // first turnaround bit is left to float, second is driven low
          if (s.cnt == 6'h00) begin
            if (rd_go) begin
              next_s.mdio_oe = 1'b1; // RL23
              next_s.mdio_o  = 1'b0;
            end
          end else begin
            next_s.cnt    = 6'h00;
            next_s.mstate = MS_DATA;
            next_s.mdio_o = s.rdata[15];
            next_s.rdata  = {s.rdata[14:0], 1'b0};
          end
        end
        MS_DATA: begin
          next_s.shreg  = sh_word;
          next_s.mdio_o = s.rdata[15];
          next_s.rdata  = {s.rdata[14:0], 1'b0};
          if (s.cnt == 6'h0F) begin
            next_s.cnt     = 6'h00;
            next_s.mdio_oe = 1'b0;
            next_s.mdio_o  = 1'b0;
            next_s.mstate  = MS_PRE;
            ctl_wr         = wr_go && (s.regad == REG_CTRL); // RL23
          end
        end
        default: begin
          next_s.mstate = MS_PRE;
        end
      endcase
    end

    // while reset runs, writes are dropped and defaults are reapplied each cycle
    if (busy) begin
      next_s.srst_cnt = s.srst_cnt - 5'h01;
      next_s.strap10  = TEN_MBPS_ONLY_ADVERT_STRAP;
      next_s.dup      = 1'b0;
      ctl_wr          = 1'b1;
      ctl_word        = CTRL_RESET_VAL; // RL1
    end else if (ctl_wr && ctl_word[CB_RESET]) begin
      next_s.srst_cnt = SOFT_RST_CYC; // RL1
      ctl_wr          = 1'b0;
    end

    if (ctl_wr) begin
      next_s.loop    = ctl_word[CB_LOOP]; // RL2
      next_s.speed   = ctl_word[CB_SPEED]; // RL5
      next_s.aneg    = ctl_word[CB_ANEN]; // RL6
      next_s.pdown   = ctl_word[CB_PDOWN]; // RL7
      next_s.iso     = ctl_word[CB_ISO]; // RL8
      next_s.restart = ctl_word[CB_ANRST]; // RL9
      if (!ctl_word[CB_ANEN]) begin
        next_s.dup = ctl_word[CB_DUP]; // RL10
      end
      next_s.coll = ctl_word[CB_COLL]; // RL12
      next_s.rsvd = ctl_word[CB_COLL-1:0]; // RL13
    end

    // loopback entry blanks receive valid while the descrambler resyncs
    loop_entry    = loop_eff & ~s.loop_q;
    dead          = loop_entry | (s.dead_cnt != 4'h0);
    next_s.loop_q = loop_eff;
    if (loop_entry) begin
      next_s.dead_cnt = 4'(LOOP_DEAD_CYC - 1); // RL3
    end else if (s.dead_cnt != 4'h0) begin
      next_s.dead_cnt = s.dead_cnt - 4'h1;
    end

    rx_src = loop_eff ? MAC_TX : LINE_RX; // RL2
    if (loop_eff && dead) begin
      rx_src.en = 1'b0; // RL3
    end
    if (s.iso) begin
      next_s.mac_rx  = '0; // RL8
      next_s.line_tx = '0;
    end else begin
      next_s.mac_rx  = rx_src;
      next_s.line_tx = s.pdown ? '0 : MAC_TX; // RL7
    end

    next_s.mode.loopback     = loop_eff;
    next_s.mode.speed_100    = s.aneg ? LIVE.an_speed_100 : s.speed; // RL5 RL6
    next_s.mode.full_duplex  = loop_eff | (s.aneg ? LIVE.an_full_duplex : s.dup); // RL6 RL11
    next_s.mode.aneg_en      = s.aneg;
    next_s.mode.aneg_restart = s.restart; // RL9
    next_s.mode.power_down   = s.pdown; // RL7
    next_s.mode.isolate      = s.iso; // RL8
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign MDIO_O  = s.mdio_o;
  assign MDIO_OE = s.mdio_oe;
  assign MODE    = s.mode;
  assign MAC_RX  = s.mac_rx;
  assign LINE_TX = s.line_tx;

  // checks

  property p_srst_defaults;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      busy |=> (!s.loop && s.speed && s.aneg && !s.pdown && !s.iso && !s.dup && s.coll && s.rsvd == 7'h00);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults) else $error("reset did not restore defaults"); // RL1

  property p_srst_len;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(busy) |-> busy [*8];
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("reset ended too early"); // RL1

  property p_loop_route;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (loop_eff && !dead && !s.iso) |=> (MAC_RX == $past(MAC_TX));
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback nibble not returned"); // RL2

  sequence s_loop_enter;
    !loop_eff ##1 loop_eff;
  endsequence

  property p_dead_time;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      s_loop_enter |=> (!MAC_RX.en) [*8];
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("receive valid during dead time"); // RL3

  property p_cfg_loop;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      LOOP_CFG_VALID |=> (MODE.loopback == $past(LOOP_CFG));
  endproperty
  a_cfg_loop: assert property (p_cfg_loop) else $error("config loopback not obeyed"); // RL4

  property p_aneg_dup;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (s.aneg && !loop_eff) |=> (MODE.full_duplex == $past(LIVE.an_full_duplex));
  endproperty
  a_aneg_dup: assert property (p_aneg_dup) else $error("forced duplex used under negotiation"); // RL6

  property p_restart_pulse;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      s.restart |=> !s.restart ##0 MODE.aneg_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart did not self clear"); // RL9

  property p_isolate;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      s.iso |=> (MAC_RX == '0 && LINE_TX == '0 && MODE.isolate);
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolate leaked data"); // RL8

  sequence s_rd_turn;
    mdc_rise && s.mstate == MS_TA && s.cnt == 6'h00 && rd_go;
  endsequence

  property p_rd_drive;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      s_rd_turn |=> (MDIO_OE && !MDIO_O);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read turnaround not driven"); // RL23
endmodule : pbr_regs

// ==== verification/pbr_station.sv ====
module pbr_station
  import pbr_pkg::*;
(
  // clock
  input  wire logic clk,
  // management lines
  output logic      mdc,
  output logic      drv,
  output logic      drv_oe,
  input  wire logic wire_lvl
);
  timeunit 1ns;
  timeprecision 1ns;

  // the management clock stands low between frames
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_oe = 1'b0;
  end

  // low half presents the bit, the line is sampled where the clock is raised
  task automatic slot(input logic b, input logic oe, output logic s);
    @(posedge clk);
    mdc <= 1'b0;
    drv <= b;
    drv_oe <= oe;
    repeat (2) @(posedge clk);
    s = wire_lvl;
    mdc <= 1'b1;
    @(posedge clk);
  endtask : slot

  // pre below 32 gives a shortened preamble
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        wr;
    hdr = {2'b01, op, phy, ra};
    wr = (op == OP_WR);
    rd = 16'h0000;
    for (int i = 32 - pre; i < 64; i++) begin
      if (i < 32) slot(1'b1, 1'b1, s);
      else if (i < 46) slot(hdr[45 - i], 1'b1, s);
      else if (i < 48) slot(i == 46, wr, s);
      else begin
        slot(wd[63 - i], wr, s);
        rd[63 - i] = s;
      end
    end
    @(posedge clk);
    mdc <= 1'b0;
    drv_oe <= 1'b0;
  endtask : frame
endmodule : pbr_station

// ==== verification/pbr_regs_tb.sv ====
module pbr_regs_tb;
  import pbr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [4:0] PA = 5'h0B;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        strap   = 1'b0;
  logic        lcv     = 1'b0;
  logic        lcfg    = 1'b0;
  pbr_live_t   live    = '{link_ok: 1'b1, aneg_done: 1'b1, remote_fault: 1'b1, an_full_duplex: 1'b1, default: 1'b0};
  pbr_mii_t    mac_tx  = '0;
  pbr_mii_t    line_rx = '0;
  pbr_mode_t   mode;
  pbr_mii_t    mac_rx;
  pbr_mii_t    line_tx;
  logic        mdc;
  logic        mdio_o;
  logic        mdio_oe;
  logic        st_drv;
  logic        st_oe;
  logic        mdio;
  logic [15:0] m       = 16'h3080;
  logic [15:0] d;
  logic        lp;
  logic        link_m  = 1'b0;
  logic        jab_m   = 1'b0;
  logic        strap_m = 1'b0;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          pulses     = 0;
  int          seed       = 1;

  always #25 clk_sys = ~clk_sys;
  // a released line floats high through the bus pull-up
  assign mdio = mdio_oe ? mdio_o : (st_oe ? st_drv : 1'b1);

  pbr_regs i_pbr_regs (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PHY_ADDR(PA), .MDC(mdc), .MDIO_I(mdio),
    .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .TEN_MBPS_ONLY_ADVERT_STRAP(strap), .LOOP_CFG_VALID(lcv),
    .LOOP_CFG(lcfg), .LIVE(live), .MODE(mode), .MAC_TX(mac_tx), .MAC_RX(mac_rx), .LINE_TX(line_tx),
    .LINE_RX(line_rx));
  pbr_station i_pbr_station (.clk(clk_sys), .mdc(mdc), .drv(st_drv), .drv_oe(st_oe), .wire_lvl(mdio));

  // latch model: events seen between reads stay until the next status read
  always @(posedge clk_sys) begin
    if (mode.aneg_restart === 1'b1) pulses++;
    if (live.link_ok !== 1'b1) link_m = 1'b0;
    // jabber only counts while the link runs at 10 Mbps
    if (live.jabber === 1'b1 && mode.speed_100 === 1'b0) jab_m = 1'b1;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic rd(input logic [4:0] ph, input logic [4:0] ra, input logic [15:0] e, input string nm);
    i_pbr_station.frame(32, OP_RD, ph, ra, 16'h0000, d);
    chk(nm, e, d);
  endtask : rd

  // duplex reads 1 while negotiation is on
  task automatic rd_ctrl();
    rd(PA, REG_CTRL, {m[15:9], m[8] | m[12], m[7:0]}, "ctrl");
  endtask : rd_ctrl

  task automatic rd_stat();
    rd(PA, REG_STAT, {1'b0, {2{~strap_m}}, 7'h60, live.aneg_done, live.remote_fault, 1'b1, link_m, jab_m, 1'b1},
       "status");
    link_m = live.link_ok;
    jab_m = 1'b0;
  endtask : rd_stat

  task automatic wr(input logic [15:0] v);
    i_pbr_station.frame(32, OP_WR, PA, REG_CTRL, v, d);
    m = {1'b0, v[14:10], 1'b0, v[12] ? m[8] : v[8], v[7:0]};
  endtask : wr

  task automatic chk_mode();
    lp = lcv ? lcfg : m[14];
    repeat (3) @(posedge clk_sys);
    chk("mode", {9'h0, lp, m[12] ? live.an_speed_100 : m[13], lp | (m[12] ? live.an_full_duplex : m[8]), m[12],
        1'b0, m[11], m[10]}, {9'h0, mode});
  endtask : chk_mode

  // sampled long after any loopback entry, so the dead time has passed
  task automatic chk_dp();
    pbr_mii_t tx;
    pbr_mii_t rx;
    repeat (4) begin
      @(posedge clk_sys);
      tx = mac_tx;
      rx = line_rx;
      {mac_tx, line_rx} <= 10'($random(seed));
      #1;
      chk("mac_rx", m[10] ? 16'h0 : {11'h0, lp ? tx : rx}, {11'h0, mac_rx});
      if (!lp) chk("line_tx", (m[10] | m[11]) ? 16'h0 : {11'h0, tx}, {11'h0, line_tx});
    end
  endtask : chk_dp

  initial begin
    logic [15:0] v;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_ctrl();
    rd_stat();
    rd_stat();
    rd(PA + 5'h1, REG_CTRL, 16'hFFFF, "other_phy");
    rd(PA, 5'h05, 16'h0000, "unmapped");
    i_pbr_station.frame(31, OP_WR, PA, REG_CTRL, 16'h4000, d);
    i_pbr_station.frame(32, OP_WR, PA, REG_STAT, 16'h0000, d);
    rd_ctrl();
    rd_stat();
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      {lcv, lcfg} <= 2'($random(seed));
      {live.an_speed_100, live.an_full_duplex} <= 2'($random(seed));
      v = 16'($random(seed)) & 16'h7D80;
      wr(v);
      rd_ctrl();
      chk_mode();
      chk_dp();
    end
    $display("test random control done");
    @(posedge clk_sys);
    {lcv, lcfg} <= 2'b00;
    live.an_speed_100 <= 1'b0;
    pulses = 0;
    wr(16'h1200);
    repeat (4) @(posedge clk_sys);
    chk("restart_pulses", 16'h0001, 16'(pulses));
    rd_ctrl();
    $display("test restart done");
    // valid must stay low from the entry cycle until the dead time has run out
    @(posedge clk_sys);
    mac_tx <= '{en: 1'b1, d: 4'h5};
    {lcv, lcfg} <= 2'b11;
    for (int k = 1; k <= LOOP_DEAD_CYC + 1; k++) begin
      @(posedge clk_sys);
      #1;
      chk("dead_en", (k > LOOP_DEAD_CYC) ? 16'h0001 : 16'h0000, {15'h0, mac_rx.en});
    end
    @(posedge clk_sys);
    {lcv, lcfg} <= 2'b00;
    $display("test dead time done");
    live.link_ok <= 1'b0;
    live.jabber <= 1'b1;
    live.remote_fault <= 1'b0;
    live.aneg_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
    live.link_ok <= 1'b1;
    live.jabber <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd_stat();
    rd_stat();
    $display("test latches done");
    i_pbr_station.frame(32, OP_WR, PA, REG_CTRL, 16'h8000, d);
    m = 16'h3080;
    link_m = 1'b0;
    rd_ctrl();
    rd_stat();
    $display("test soft reset done");
    strap <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    strap_m = 1'b1;
    link_m = 1'b0;
    rd_stat();
    rd_ctrl();
    $display("test strap done");
    results();
  end

  // about 9000 cycles are expected; 40000 cycles means a hang
  initial begin
    #(40000 * 50);
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    results();
  end
endmodule : pbr_regs_tb
